// >>> logic/spcr_defs.svh
// Purpose: constants of the serial configuration port
// Assumes: 25 MHz system clock
// Notes:   offsets are register addresses in the 7-bit space
`ifndef SPCR_DEFS_SVH
`define SPCR_DEFS_SVH

`define SPCR_ADDR_W         7
`define SPCR_DEPTH          128
`define SPCR_RST_BYTE       8'h00
// spi and sysref mode register
`define SPCR_MODE_ADDR      7'h1F
`define SPCR_PULSE_MODE_BIT 0
`define SPCR_SRC_SEL_BIT    1
`define SPCR_RD_EDGE_BIT    2
`define SPCR_FOUR_WIRE_BIT  3
// sysref start register
`define SPCR_START_ADDR     7'h70
`define SPCR_START_BIT      0
// divider init and pll_request_a register
`define SPCR_ACT_ADDR       7'h71
`define SPCR_INIT_BIT       0
`define SPCR_PLL_REQUEST_A_BIT     1
// divider synchronisation time
`define SPCR_CLK_PERIOD_NS  40
`define SPCR_INIT_TIME_NS   400
`define SPCR_INIT_CYCLES    ((`SPCR_INIT_TIME_NS + `SPCR_CLK_PERIOD_NS - 1) / `SPCR_CLK_PERIOD_NS)
`define SPCR_INIT_CNT_W     4

`endif

// >>> logic/spcr_pkg.sv
// Purpose: types of the serial configuration port
// Assumes: nothing
// Notes:   phase of the current serial byte
package spcr_pkg;
  typedef enum logic [1:0] {
    SPCR_HDR,
    SPCR_WR,
    SPCR_RD
  } spcr_phase_e;
endpackage

// >>> logic/spcr_top.sv
// Purpose: serial configuration port slave with divider init, pll_request_a and sysref start
// Assumes: pins synchronous to CLK_SYS, serial clock well below half of CLK_SYS
// Notes:   register space is a 128 byte array
// Overview of operation
// - port starts in 3-wire mode; 4-wire only when four-wire select is set
// - 3-wire uses bidirectional data pin; 4-wire reads drive the separate output
// - chip select high floats the data pin and idles the port
// - serial input data is sampled on the rising clock edge
// - read data changes on falling edge, or rising edge with read-edge select
// - first byte is direction bit then seven address bits, LSB first
// - after a read header, load register and shift it out over 8 clocks
// - reads auto-increment and return successive registers while selected
// - a write stores the completed data byte into the addressed register
// - writes auto-increment the address for each further byte
// - init bit syncs dividers, holds outputs low, then clears itself
// - internal source: start bit produces pulses; host sets it each time
// - external source: pulses at next external rising edge after start
// - sysref start bit clears itself once acted on
`timescale 1ns/100ps
`include "spcr_defs.svh"
module spcr_top (
  // clock and reset
  input  wire logic CLK_SYS,
  input  wire logic RST,
  // serial port
  input  wire logic SCLK,
  input  wire logic CS_N,
  input  wire logic SERIAL_DATA_IO_I,
  output logic      SERIAL_DATA_IO_O,
  output logic      SERIAL_DATA_IO_OE,
  output logic      SDO_O,
  output logic      SDO_OE,
  // sysref
  input  wire logic EXTERNAL_SYSREF_INPUT,
  output logic      SYSREF_FIRE,
  output logic      SYSREF_PULSE_MODE,
  output logic      SYSREF_SOURCE_SELECT,
  // divider sync and pll
  output logic      OUTPUTS_HOLD_LOW,
  output logic      PLL_REQUEST_A,
  // port mode status
  output logic      FOUR_WIRE_SELECT,
  output logic      READ_EDGE_SELECT
);

  function automatic logic [`SPCR_ADDR_W-1:0] inc_addr(input logic [`SPCR_ADDR_W-1:0] a);
    inc_addr = `SPCR_ADDR_W'(a + 7'h01);
  endfunction

  logic [7:0]                  mem_ff [`SPCR_DEPTH];
  logic                        sclk_ff;
  logic                        sclk_prev_ff;
  logic                        cs_n_ff;
  logic                        sdi_ff;
  logic                        ext_ff;
  logic                        ext_prev_ff;
  spcr_pkg::spcr_phase_e       phase_ff;
  logic [2:0]                  bit_cnt_ff;
  logic [7:0]                  rx_sh_ff;
  logic [7:0]                  tx_sh_ff;
  logic [`SPCR_ADDR_W-1:0]     addr_ff;
  logic                        sdo_bit_ff;
  logic                        io_oe_ff;
  logic                        sdo_oe_ff;
  logic [`SPCR_INIT_CNT_W-1:0] init_cnt_ff;
  logic [`SPCR_INIT_CNT_W-1:0] nxt_init_cnt;
  logic                        hold_ff;
  logic                        pll_request_a_pulse_ff;
  logic                        fire_ff;

  // decode
  wire       rise        = sclk_ff & ~sclk_prev_ff & ~cs_n_ff;
  wire       fall        = ~sclk_ff & sclk_prev_ff & ~cs_n_ff;
  wire       byte_done   = rise & (bit_cnt_ff == 3'h7);
  wire [7:0] rx_byte     = {sdi_ff, rx_sh_ff[7:1]};
  wire       in_hdr      = (phase_ff == spcr_pkg::SPCR_HDR);
  wire       in_rd       = (phase_ff == spcr_pkg::SPCR_RD);
  wire       hdr_done    = byte_done & in_hdr;
  wire       wr_strobe   = byte_done & (phase_ff == spcr_pkg::SPCR_WR);
  wire       rd_load     = byte_done & ((in_hdr & rx_byte[0]) | in_rd);
  wire [`SPCR_ADDR_W-1:0] load_addr = in_hdr ? rx_byte[7:1] : inc_addr(addr_ff);
  wire [7:0] load_data   = mem_ff[load_addr];
  wire       four_wire   = mem_ff[`SPCR_MODE_ADDR][`SPCR_FOUR_WIRE_BIT];
  wire       rd_edge     = mem_ff[`SPCR_MODE_ADDR][`SPCR_RD_EDGE_BIT];
  wire       src_ext     = mem_ff[`SPCR_MODE_ADDR][`SPCR_SRC_SEL_BIT];
  wire       init_req    = mem_ff[`SPCR_ACT_ADDR][`SPCR_INIT_BIT];
  wire       pll_request_a_req  = mem_ff[`SPCR_ACT_ADDR][`SPCR_PLL_REQUEST_A_BIT];
  wire       start_req   = mem_ff[`SPCR_START_ADDR][`SPCR_START_BIT];
  wire       drive_edge  = in_rd & (rd_edge ? (rise & ~byte_done) : fall);
  wire       init_go     = init_req & (init_cnt_ff == '0);
  wire       init_end    = (init_cnt_ff == `SPCR_INIT_CNT_W'(1));
  wire       ext_rise    = ext_ff & ~ext_prev_ff;
  wire       sr_go       = start_req & (~src_ext | ext_rise);

  always_comb begin
    if (init_go) begin
      nxt_init_cnt = `SPCR_INIT_CNT_W'(`SPCR_INIT_CYCLES);
    end else if (init_cnt_ff != '0) begin
      nxt_init_cnt = `SPCR_INIT_CNT_W'(init_cnt_ff - 4'h1);
    end else begin
      nxt_init_cnt = init_cnt_ff;
    end
  end

  // pin sampling
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      sclk_ff      <= 1'b0;
      sclk_prev_ff <= 1'b0;
      cs_n_ff      <= 1'b1;
      sdi_ff       <= 1'b0;
      ext_ff       <= 1'b0;
      ext_prev_ff  <= 1'b0;
    end else begin
      sclk_ff      <= SCLK;
      sclk_prev_ff <= sclk_ff;
      cs_n_ff      <= CS_N;
      sdi_ff       <= SERIAL_DATA_IO_I;
      ext_ff       <= EXTERNAL_SYSREF_INPUT;
      ext_prev_ff  <= ext_ff;
    end
  end

  // byte framing and address
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      phase_ff   <= spcr_pkg::SPCR_HDR;
      bit_cnt_ff <= 3'h0;
      rx_sh_ff   <= 8'h00;
      addr_ff    <= 7'h00;
    end else if (cs_n_ff) begin
      phase_ff   <= spcr_pkg::SPCR_HDR;
      bit_cnt_ff <= 3'h0;
    end else if (rise) begin
      rx_sh_ff   <= rx_byte;
      bit_cnt_ff <= 3'(bit_cnt_ff + 3'h1);
      if (hdr_done) begin
        phase_ff <= rx_byte[0] ? spcr_pkg::SPCR_RD : spcr_pkg::SPCR_WR;
        addr_ff  <= rx_byte[7:1];
      end else if (byte_done) begin
        addr_ff  <= inc_addr(addr_ff);
      end
    end
  end

  // read shifter and pin drivers
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      tx_sh_ff   <= 8'h00;
      sdo_bit_ff <= 1'b0;
      io_oe_ff   <= 1'b0;
      sdo_oe_ff  <= 1'b0;
    end else begin
      if (rd_load) begin
        tx_sh_ff <= rd_edge ? {1'b0, load_data[7:1]} : load_data;
        if (rd_edge) begin
          sdo_bit_ff <= load_data[0];
        end
      end else if (drive_edge) begin
        sdo_bit_ff <= tx_sh_ff[0];
        tx_sh_ff   <= {1'b0, tx_sh_ff[7:1]};
      end
      io_oe_ff  <= ~cs_n_ff & in_rd & ~four_wire;
      sdo_oe_ff <= ~cs_n_ff & in_rd & four_wire;
    end
  end

  // register file and self-clearing bits; a write in the clearing cycle wins
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      for (int i = 0; i < `SPCR_DEPTH; i++) begin
        mem_ff[i] <= `SPCR_RST_BYTE;
      end
    end else begin
      if (init_end) begin
        mem_ff[`SPCR_ACT_ADDR][`SPCR_INIT_BIT] <= 1'b0;
      end
      if (pll_request_a_req) begin
        mem_ff[`SPCR_ACT_ADDR][`SPCR_PLL_REQUEST_A_BIT] <= 1'b0;
      end
      if (sr_go) begin
        mem_ff[`SPCR_START_ADDR][`SPCR_START_BIT] <= 1'b0;
      end
      if (wr_strobe) begin
        mem_ff[addr_ff] <= rx_byte;
      end
    end
  end

  // divider init, pll_request_a and sysref actions
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      init_cnt_ff     <= '0;
      hold_ff         <= 1'b0;
      pll_request_a_pulse_ff <= 1'b0;
      fire_ff         <= 1'b0;
    end else begin
      init_cnt_ff     <= nxt_init_cnt;
      hold_ff         <= (nxt_init_cnt != '0);
      pll_request_a_pulse_ff <= pll_request_a_req;
      fire_ff         <= sr_go;
    end
  end

  assign SERIAL_DATA_IO_O     = sdo_bit_ff;
  assign SERIAL_DATA_IO_OE    = io_oe_ff;
  assign SDO_O                = sdo_bit_ff;
  assign SDO_OE               = sdo_oe_ff;
  assign SYSREF_FIRE          = fire_ff;
  assign SYSREF_PULSE_MODE    = mem_ff[`SPCR_MODE_ADDR][`SPCR_PULSE_MODE_BIT];
  assign SYSREF_SOURCE_SELECT = src_ext;
  assign OUTPUTS_HOLD_LOW     = hold_ff;
  assign PLL_REQUEST_A        = pll_request_a_pulse_ff;
  assign FOUR_WIRE_SELECT     = four_wire;
  assign READ_EDGE_SELECT     = rd_edge;

  // checks
  logic [`SPCR_ADDR_W-1:0] chk_wr_addr_ff;
  logic [7:0]              chk_wr_data_ff;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      chk_wr_addr_ff <= 7'h00;
      chk_wr_data_ff <= 8'h00;
    end else begin
      chk_wr_addr_ff <= addr_ff;
      chk_wr_data_ff <= rx_byte;
    end
  end

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);

  idle_float_a: assert property (cs_n_ff |=> !io_oe_ff && !sdo_oe_ff)
    else $error("data pins driven while deselected");
  sdo_mode_a: assert property (sdo_oe_ff |-> $past(four_wire))
    else $error("separate output driven in 3-wire mode");
  pin_excl_a: assert property (!(io_oe_ff && sdo_oe_ff))
    else $error("both data outputs enabled");
  rx_edge_a: assert property (!rise |=> $stable(rx_sh_ff))
    else $error("input shifted without rising clock");
  out_edge_a: assert property ($changed(sdo_bit_ff) && !$past(rd_edge) |-> $past(fall))
    else $error("read data changed off the falling edge");
  rd_enter_a: assert property (hdr_done && rx_byte[0] |=> in_rd)
    else $error("read header did not enter read phase");
  addr_step_a: assert property (byte_done && !in_hdr |=> addr_ff == $past(addr_ff) + 7'h01)
    else $error("address did not auto-increment");
  wr_store_a: assert property (wr_strobe |=> mem_ff[chk_wr_addr_ff] == chk_wr_data_ff)
    else $error("write byte not stored");
  init_hold_a: assert property (init_go |=> hold_ff [*8] ##1 hold_ff)
    else $error("outputs not held low during init");
  init_clear_a: assert property (init_go |-> ##[1:12] !hold_ff && (init_cnt_ff == '0))
    else $error("init did not finish in time");
  pll_request_a_pulse_a: assert property (pll_request_a_req |=> PLL_REQUEST_A)
    else $error("pll_request_a request not issued");
  sr_int_a: assert property (start_req && !src_ext |=> fire_ff)
    else $error("internal sysref start not acted on");
  sr_ext_a: assert property (start_req && src_ext && !ext_rise |=> !fire_ff)
    else $error("external sysref fired without edge");
  init_len_a: assert property (init_go |-> ##10 hold_ff ##1 !hold_ff)
    else $error("init hold length wrong");
  init_bit_clr_a: assert property (init_end && !wr_strobe |=> !init_req)
    else $error("init bit not cleared at end of init");
  sr_clr_a: assert property (sr_go && !wr_strobe |=> !start_req)
    else $error("sysref start bit not cleared");
  rd_oe_a: assert property (in_rd && !cs_n_ff && !four_wire |=> io_oe_ff)
    else $error("data pin not turned to output in read");
  four_oe_a: assert property (in_rd && !cs_n_ff && four_wire |=> sdo_oe_ff)
    else $error("separate output not enabled in 4-wire read");
  idle_oe_a: assert property (!in_rd |=> !io_oe_ff && !sdo_oe_ff)
    else $error("output enabled outside read phase");
  hdr_addr_a: assert property (hdr_done |=> addr_ff == $past(rx_byte[7:1]))
    else $error("header address not taken");
  wr_phase_a: assert property (hdr_done && !rx_byte[0] |=> !in_hdr && !in_rd)
    else $error("write header did not enter write phase");
  pll_request_a_once_a: assert property (PLL_REQUEST_A |=> !PLL_REQUEST_A)
    else $error("pll_request_a request longer than one cycle");
  fire_once_a: assert property (fire_ff |=> !fire_ff)
    else $error("sysref fire longer than one cycle");
  bit_clr_a: assert property (cs_n_ff |=> bit_cnt_ff == 3'h0)
    else $error("bit count kept while deselected");
  bit_step_a: assert property (rise |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'h1)
    else $error("bit count did not step on rising edge");
  rd_shift_a: assert property (rd_load && !rd_edge |=> tx_sh_ff == $past(load_data))
    else $error("read register not loaded into shifter");
  rd_lsb_a: assert property (rd_load && rd_edge |=> sdo_bit_ff == $past(load_data[0]))
    else $error("first read bit not presented at byte end");

  wr_seen_c: cover property (wr_strobe ##[1:200] wr_strobe);
  rd_seen_c: cover property (hdr_done && rx_byte[0] ##[1:200] rd_load);
  init_seen_c: cover property (init_go ##[1:1000] pll_request_a_req);
  edge_rd_c: cover property (rd_load && rd_edge);
  ext_fire_c: cover property (start_req && src_ext && ext_rise);

endmodule

// >>> dv/spcr_master.sv
// Purpose: serial master model driving the configuration port
// Assumes: sclk low for 6 and high for 7 system clocks, sclk idles low between frames
// Notes:   sends whole bytes only; lets go of the data line 2 clocks after each rising edge
`timescale 1ns/100ps
module spcr_master (
  // system clock
  input  wire logic clk,
  // serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi,
  output logic      mosi_oe,
  input  wire logic miso
);
  localparam int HALF = 6;
  logic [7:0] wr_b [4];
  logic [7:0] rd_b [4];

  initial begin
    sclk    = 1'b0;
    cs_n    = 1'b1;
    mosi    = 1'b0;
    mosi_oe = 1'b0;
  end

  // one byte lsb first, sampled just before each rising edge
  task automatic shift_byte(input logic [7:0] d, input logic drv, output logic [7:0] q);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      sclk    <= 1'b0;
      mosi    <= d[i];
      mosi_oe <= drv;
      repeat (HALF) @(posedge clk);
      q[i] = miso;
      sclk <= 1'b1;
      repeat (2) @(posedge clk);
      mosi_oe <= 1'b0;
      repeat (HALF - 2) @(posedge clk);
    end
  endtask

  // header then n data bytes in one selected frame
  task automatic xfer(input logic rd, input logic [6:0] a, input int n);
    logic [7:0] junk;
    @(posedge clk);
    cs_n <= 1'b0;
    shift_byte({a, rd}, 1'b1, junk);
    for (int k = 0; k < n; k++)
      shift_byte(wr_b[k], !rd, rd_b[k]);
    @(posedge clk);
    sclk <= 1'b0;
    repeat (HALF) @(posedge clk);
    cs_n <= 1'b1;
    repeat (HALF) @(posedge clk);
  endtask
endmodule

// >>> dv/tb_top.sv
// Purpose: self-checking bench of the serial configuration port
// Assumes: 25 MHz system clock, master model on the serial pins
// Notes:   a released data line toggles every clock so stale values never pass
`timescale 1ns/100ps
module tb_top;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       ext = 1'b0;
  logic       pin_last = 1'b0;
  int         failures = 0;
  int         comparisons = 0;
  int         n_fire = 0;
  int         n_pll = 0;
  int         n_hold = 0;
  wire        sclk, cs_n, m_d, m_oe, sd_o, sd_oe, so, so_oe;
  wire        fire, pmode, srcsel, hold, pll, fw, rdedge;
  wire        pin  = sd_oe ? sd_o : (m_oe ? m_d : ~pin_last);
  wire        miso = fw ? (so_oe ? so : ~pin_last) : pin;

  always #20 clk = ~clk;

  // float pattern and pulse counters
  always @(posedge clk) begin
    pin_last <= pin;
    n_fire   <= n_fire + int'(fire);
    n_pll    <= n_pll + int'(pll);
    n_hold   <= n_hold + int'(hold);
  end

  spcr_top i_dut (
    .CLK_SYS(clk), .RST(rst), .SCLK(sclk), .CS_N(cs_n),
    .SERIAL_DATA_IO_I(pin), .SERIAL_DATA_IO_O(sd_o), .SERIAL_DATA_IO_OE(sd_oe),
    .SDO_O(so), .SDO_OE(so_oe), .EXTERNAL_SYSREF_INPUT(ext),
    .SYSREF_FIRE(fire), .SYSREF_PULSE_MODE(pmode), .SYSREF_SOURCE_SELECT(srcsel),
    .OUTPUTS_HOLD_LOW(hold), .PLL_REQUEST_A(pll),
    .FOUR_WIRE_SELECT(fw), .READ_EDGE_SELECT(rdedge)
  );

  spcr_master i_mst (
    .clk(clk), .sclk(sclk), .cs_n(cs_n), .mosi(m_d), .mosi_oe(m_oe), .miso(miso)
  );

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // single byte write, all addresses kept below 0x78
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    i_mst.wr_b[0] = d;
    i_mst.xfer(1'b0, a, 1);
  endtask

  task automatic t_basic();
    chk({fw, rdedge, sd_oe, so_oe, fire, pll, hold, srcsel | pmode}, 8'h00);
    i_mst.wr_b[0] = 8'hA5;
    i_mst.wr_b[1] = 8'h5A;
    i_mst.wr_b[2] = 8'hC3;
    i_mst.wr_b[3] = 8'h00;
    i_mst.xfer(1'b0, 7'h10, 3);
    i_mst.xfer(1'b1, 7'h10, 4);
    for (int k = 0; k < 4; k++) chk(i_mst.rd_b[k], i_mst.wr_b[k]);
    chk({7'h00, sd_oe}, 8'h00);
  endtask

  // every read edge and wire mode, register readback in each
  task automatic t_modes();
    logic [7:0] m;
    for (int j = 0; j < 4; j++) begin
      m = 8'(j * 4);
      wr(7'h1F, m);
      chk({4'h0, fw, rdedge, srcsel, pmode}, m);
      i_mst.xfer(1'b1, 7'h1F, 2);
      chk(i_mst.rd_b[0], m);
      chk(i_mst.rd_b[1], 8'h00);
      i_mst.xfer(1'b1, 7'h11, 2);
      chk(i_mst.rd_b[0], 8'h5A);
      chk(i_mst.rd_b[1], 8'hC3);
    end
    wr(7'h1F, 8'h00);
  endtask

  task automatic t_sync();
    int h0;
    int p0;
    h0 = n_hold;
    p0 = n_pll;
    wr(7'h71, 8'h01);
    repeat (20) @(posedge clk);
    chk(8'(n_hold - h0), 8'h0A);
    i_mst.xfer(1'b1, 7'h71, 1);
    chk(i_mst.rd_b[0], 8'h00);
    wr(7'h71, 8'h02);
    chk(8'(n_pll - p0), 8'h01);
    i_mst.xfer(1'b1, 7'h71, 1);
    chk(i_mst.rd_b[0], 8'h00);
  endtask

  task automatic t_sysref();
    int f0;
    f0 = n_fire;
    wr(7'h1F, 8'h01);
    chk({6'h00, srcsel, pmode}, 8'h01);
    wr(7'h70, 8'h01);
    wr(7'h70, 8'h01);
    chk(8'(n_fire - f0), 8'h02);
    i_mst.xfer(1'b1, 7'h70, 1);
    chk(i_mst.rd_b[0], 8'h00);
    wr(7'h1F, 8'h03);
    chk({6'h00, srcsel, pmode}, 8'h03);
    wr(7'h70, 8'h01);
    chk(8'(n_fire - f0), 8'h02);
    ext <= 1'b1;
    for (int k = 0; k < 10 && n_fire == f0 + 2; k++) @(posedge clk);
    chk(8'(n_fire - f0), 8'h03);
    if (n_fire == f0 + 2) return;
    ext <= 1'b0;
    i_mst.xfer(1'b1, 7'h70, 1);
    chk(i_mst.rd_b[0], 8'h00);
  endtask

  task automatic final_report();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    t_basic();
    t_modes();
    t_sync();
    t_sysref();
    final_report();
  end
endmodule
